// >>> logic/ocs_pkg.sv
/*
 Package for the output clock select register block: register offsets,
 field positions, reset values, frequency codes and the carrier structs.
 Assumes an 8-bit register port, a strap bus of three pins and a 25 MHz clock.
*/
package ocs_pkg;

    localparam logic [7:0]  OCS_ADDR_AUX      = 8'h35;
    localparam logic [7:0]  OCS_ADDR_STRAP    = 8'h37;
    localparam logic [7:0]  OCS_ADDR_OE       = 8'h38;
    localparam logic [7:0]  OCS_ADDR_FREQ     = 8'h39;
    localparam logic [7:0]  OCS_ADDR_IF_SEL   = 8'h7F;

    localparam logic [7:0]  OCS_RST_AUX       = 8'h00;
    localparam logic [7:0]  OCS_RST_OE        = 8'h1F;
    localparam logic [7:0]  OCS_RST_FREQ      = 8'h04;
    localparam logic [2:0]  OCS_RST_IF        = 3'h0;

    localparam logic [7:0]  OCS_AUX_MASK      = 8'h3F;
    localparam logic [7:0]  OCS_OE_MASK       = 8'h7F;
    localparam logic [7:0]  OCS_FREQ_MASK     = 8'hF3;

    localparam int          OCS_OE_FAM_B      = 6;
    localparam int          OCS_OE_FAM_A      = 5;
    localparam int          OCS_OE_PORT2      = 4;
    localparam int          OCS_OE_PORT3      = 2;
    localparam int          OCS_FQ_B_LSB      = 6;
    localparam int          OCS_FQ_A_LSB      = 4;
    localparam int          OCS_FQ_P2_LSB     = 0;

    // Frequencies in kHz
    localparam logic [15:0] OCS_KHZ_SONET     = 16'h0608;
    localparam logic [15:0] OCS_KHZ_SDH       = 16'h0800;
    localparam logic [15:0] OCS_KHZ_6M48      = 16'h1950;
    localparam logic [15:0] OCS_KHZ_25M92     = 16'h6540;
    localparam logic [15:0] OCS_KHZ_19M44     = 16'h4BF0;
    localparam logic [15:0] OCS_KHZ_OFF       = 16'h0000;

    localparam logic [1:0]  OCS_P2_6M48       = 2'h0;
    localparam logic [1:0]  OCS_P2_25M92      = 2'h1;
    localparam logic [1:0]  OCS_P2_19M44      = 2'h2;
    localparam logic [1:0]  OCS_P2_COPY_A     = 2'h3;

    localparam logic [1:0]  OCS_STRAP_SETTLE  = 2'h2;
    localparam logic        OCS_STATIC_LEVEL  = 1'b0;

    typedef enum logic [2:0] {
        OCS_IF_OFF0   = 3'h0,
        OCS_IF_BOOT   = 3'h1,
        OCS_IF_MUX    = 3'h2,
        OCS_IF_PAR_A  = 3'h3,
        OCS_IF_PAR_B  = 3'h4,
        OCS_IF_SERIAL = 3'h5,
        OCS_IF_OFF6   = 3'h6,
        OCS_IF_OFF7   = 3'h7
    } ocs_if_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ocs_bus_req_type;

    typedef struct packed {
        logic        dig_a_sonet;
        logic [15:0] dig_a_khz;
        logic        dig_b_sonet;
        logic [15:0] dig_b_khz;
        logic        port_two_en;
        logic [15:0] port_two_khz;
        logic        port_two_level;
        logic        port_three_en;
        logic [15:0] port_three_khz;
        logic        port_three_level;
        logic        e1t1_mode;
    } ocs_clk_cfg_type;

endpackage

// >>> logic/ocs_sync.sv
/*
 Two flip-flop synchroniser for a bus of slowly changing levels.
 Assumes each bit is an independent static level such as a strap pin.
*/
`timescale 1ns/1ps
module ocs_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// >>> logic/ocs_output_clock_select.sv
/*
 Output clock select register block: register port, strap readback,
 active host interface type and the resolved output clock configuration.
 Assumes the straps are asynchronous pins, the E1/T1 select comes from
 the general control register on the same clock, and a single-cycle bus.
*/
`timescale 1ns/1ps
module ocs_output_clock_select
    import ocs_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            arst_n,
    input  wire ocs_bus_req_type bus_req,
    output logic [7:0]           rd_data,
    input  wire logic [2:0]      host_interface_strap_pins,
    input  wire logic            e1t1_select,
    output ocs_if_type           active_if_type,
    output logic [5:0]           aux_pll_path_ctrl,
    output ocs_clk_cfg_type      clk_cfg
);

    logic [2:0]      strap_sync;
    logic [7:0]      aux_reg;
    logic [7:0]      oe_reg;
    logic [7:0]      freq_reg;
    logic [1:0]      settle_reg;
    logic            captured_reg;
    logic [7:0]      rd_next;
    ocs_clk_cfg_type cfg_next;
    logic            wr_aux;
    logic            wr_oe;
    logic            wr_freq;
    logic            wr_if;

    ocs_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .async_in(host_interface_strap_pins),
        .sync_out(strap_sync)
    );

    assign wr_aux  = bus_req.wr && (bus_req.addr == OCS_ADDR_AUX);
    assign wr_oe   = bus_req.wr && (bus_req.addr == OCS_ADDR_OE);
    assign wr_freq = bus_req.wr && (bus_req.addr == OCS_ADDR_FREQ);
    assign wr_if   = bus_req.wr && (bus_req.addr == OCS_ADDR_IF_SEL);

    // Aux PLL control, unused top bits never stored
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_reg <= OCS_RST_AUX;
        end else if (wr_aux) begin
            aux_reg <= bus_req.wdata & OCS_AUX_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_pll_path_ctrl <= OCS_RST_AUX[5:0];
        end else begin
            aux_pll_path_ctrl <= aux_reg[5:0];
        end
    end

    // Output enable register; bit 7 unused
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            oe_reg <= OCS_RST_OE;
        end else if (wr_oe) begin
            oe_reg <= bus_req.wdata & OCS_OE_MASK;
        end
    end

    // Output frequency register; bits 3:2 unused
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_reg <= OCS_RST_FREQ;
        end else if (wr_freq) begin
            freq_reg <= bus_req.wdata & OCS_FREQ_MASK;
        end
    end

    // Wait for the strap synchroniser to fill, then latch once
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_reg   <= 2'h0;
            captured_reg <= 1'b0;
        end else if (!captured_reg) begin
            if (settle_reg == OCS_STRAP_SETTLE) begin
                captured_reg <= 1'b1;
            end else begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    // Active interface: strap at start, software override later
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_if_type <= ocs_if_type'(OCS_RST_IF);
        end else if (wr_if) begin
            active_if_type <= ocs_if_type'(bus_req.wdata[2:0]);
        end else if (!captured_reg && settle_reg == OCS_STRAP_SETTLE) begin
            active_if_type <= ocs_if_type'(strap_sync);
        end
    end

    // Read mux
    always_comb begin
        rd_next = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OCS_ADDR_AUX:    rd_next = aux_reg;
                OCS_ADDR_STRAP:  rd_next = {5'h00, strap_sync};
                OCS_ADDR_OE:     rd_next = oe_reg;
                OCS_ADDR_FREQ:   rd_next = freq_reg;
                OCS_ADDR_IF_SEL: rd_next = {5'h00, active_if_type};
                default:         rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_next;
        end
    end

    // Resolve the output clock configuration
    always_comb begin
        cfg_next             = '0;
        cfg_next.e1t1_mode   = e1t1_select;
        cfg_next.dig_a_sonet = oe_reg[OCS_OE_FAM_A];
        cfg_next.dig_b_sonet = oe_reg[OCS_OE_FAM_B];
        cfg_next.dig_a_khz   = (oe_reg[OCS_OE_FAM_A] ? OCS_KHZ_SONET : OCS_KHZ_SDH)
                               << freq_reg[OCS_FQ_A_LSB +: 2];
        cfg_next.dig_b_khz   = (oe_reg[OCS_OE_FAM_B] ? OCS_KHZ_SONET : OCS_KHZ_SDH)
                               << freq_reg[OCS_FQ_B_LSB +: 2];
        cfg_next.port_two_en      = oe_reg[OCS_OE_PORT2];
        cfg_next.port_two_level   = OCS_STATIC_LEVEL;
        cfg_next.port_two_khz     = OCS_KHZ_OFF;
        if (oe_reg[OCS_OE_PORT2]) begin
            unique case (freq_reg[OCS_FQ_P2_LSB +: 2])
                OCS_P2_6M48:   cfg_next.port_two_khz = OCS_KHZ_6M48;
                OCS_P2_25M92:  cfg_next.port_two_khz = OCS_KHZ_25M92;
                OCS_P2_19M44:  cfg_next.port_two_khz = OCS_KHZ_19M44;
                OCS_P2_COPY_A: cfg_next.port_two_khz = cfg_next.dig_a_khz;
            endcase
        end
        cfg_next.port_three_en    = oe_reg[OCS_OE_PORT3];
        cfg_next.port_three_level = OCS_STATIC_LEVEL;
        cfg_next.port_three_khz   = oe_reg[OCS_OE_PORT3] ? OCS_KHZ_19M44 : OCS_KHZ_OFF;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_cfg <= '0;
        end else begin
            clk_cfg <= cfg_next;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    a_rdata_idle_zero: assert property (
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data not zero outside read answer");

    a_strap_readback: assert property (
        bus_req.rd && bus_req.addr == OCS_ADDR_STRAP
        |=> rd_data == {5'h00, $past(strap_sync)})
        else $error("strap readback does not follow pins");

    a_strap_ro: assert property (
        bus_req.wr && bus_req.addr == OCS_ADDR_STRAP ##1
        bus_req.rd && bus_req.addr == OCS_ADDR_STRAP
        |=> rd_data[7:3] == 5'h00)
        else $error("strap readback upper bits not zero");

    a_active_stable: assert property (
        captured_reg && !wr_if |=> $stable(active_if_type))
        else $error("active interface changed without a select write");

    a_if_override: assert property (
        wr_if |=> active_if_type == ocs_if_type'($past(bus_req.wdata[2:0])))
        else $error("interface select write not applied");

    a_oe_bit7_zero: assert property (
        wr_oe ##1 bus_req.rd && bus_req.addr == OCS_ADDR_OE |=> rd_data[7] == 1'b0)
        else $error("unused enable bit reads back set");

    a_dig_b_freq: assert property (
        wr_oe or wr_freq |-> ##2 clk_cfg.dig_b_khz ==
        (($past(oe_reg[OCS_OE_FAM_B]) ? OCS_KHZ_SONET : OCS_KHZ_SDH)
         << $past(freq_reg[7:6])))
        else $error("digital output b frequency wrong");

    a_dig_a_family: assert property (
        ##1 clk_cfg.dig_a_sonet == $past(oe_reg[OCS_OE_FAM_A]))
        else $error("digital output a family wrong");

    a_port_two_off: assert property (
        !oe_reg[OCS_OE_PORT2] |=> !clk_cfg.port_two_en
        && clk_cfg.port_two_khz == OCS_KHZ_OFF && clk_cfg.port_two_level == OCS_STATIC_LEVEL)
        else $error("disabled port two not static");

    a_port_two_copy: assert property (
        oe_reg[OCS_OE_PORT2] && freq_reg[1:0] == OCS_P2_COPY_A
        |=> clk_cfg.port_two_khz == clk_cfg.dig_a_khz)
        else $error("port two does not copy output a");

    a_port_three_freq: assert property (
        arst_n && oe_reg[OCS_OE_PORT3] |=> clk_cfg.port_three_en
        && clk_cfg.port_three_khz == OCS_KHZ_19M44)
        else $error("port three not at default frequency");

    a_aux_masked: assert property (
        wr_aux |-> ##2 aux_pll_path_ctrl == $past(bus_req.wdata[5:0], 2))
        else $error("aux control not passed to the aux path");

    a_dig_a_freq: assert property (
        wr_oe || wr_freq |-> ##2 clk_cfg.dig_a_khz ==
        (($past(oe_reg[OCS_OE_FAM_A]) ? OCS_KHZ_SONET : OCS_KHZ_SDH)
         << $past(freq_reg[OCS_FQ_A_LSB +: 2])))
        else $error("digital output a frequency wrong");

    a_dig_b_family: assert property (
        wr_oe |-> ##2 clk_cfg.dig_b_sonet == $past(oe_reg[OCS_OE_FAM_B]))
        else $error("digital output b family wrong");

    a_port_two_on: assert property (
        arst_n && oe_reg[OCS_OE_PORT2] |=> clk_cfg.port_two_en)
        else $error("enabled port two not flagged");

    a_port_two_fixed: assert property (
        arst_n && oe_reg[OCS_OE_PORT2] && freq_reg[1:0] != OCS_P2_COPY_A
        |=> clk_cfg.port_two_khz ==
            ($past(freq_reg[1:0]) == OCS_P2_6M48  ? OCS_KHZ_6M48  :
             $past(freq_reg[1:0]) == OCS_P2_25M92 ? OCS_KHZ_25M92 : OCS_KHZ_19M44))
        else $error("port two fixed frequency wrong");

    a_port_three_off: assert property (
        !oe_reg[OCS_OE_PORT3] |=> !clk_cfg.port_three_en
        && clk_cfg.port_three_khz == OCS_KHZ_OFF
        && clk_cfg.port_three_level == OCS_STATIC_LEVEL)
        else $error("disabled port three not static");

    a_e1t1_follow: assert property (
        arst_n |=> clk_cfg.e1t1_mode == $past(e1t1_select))
        else $error("e1t1 mode not passed through");

    a_strap_capture: assert property (
        !captured_reg && settle_reg == OCS_STRAP_SETTLE && !wr_if
        |=> active_if_type == ocs_if_type'($past(strap_sync)))
        else $error("strap type not taken after reset");

    a_capture_once: assert property (
        captured_reg |=> captured_reg)
        else $error("strap capture repeated");

    a_if_readback: assert property (
        bus_req.rd && bus_req.addr == OCS_ADDR_IF_SEL
        |=> rd_data == {5'h00, $past(active_if_type)})
        else $error("interface select readback wrong");

    a_oe_readback: assert property (
        bus_req.rd && bus_req.addr == OCS_ADDR_OE |=> rd_data == $past(oe_reg))
        else $error("enable register readback wrong");

    a_oe_write: assert property (
        wr_oe |=> oe_reg == ($past(bus_req.wdata) & OCS_OE_MASK))
        else $error("enable register write wrong");

    a_freq_write: assert property (
        wr_freq |=> freq_reg == ($past(bus_req.wdata) & OCS_FREQ_MASK))
        else $error("frequency register write wrong");

    a_freq_readback: assert property (
        bus_req.rd && bus_req.addr == OCS_ADDR_FREQ |=> rd_data == $past(freq_reg))
        else $error("frequency register readback wrong");

    a_aux_write: assert property (
        wr_aux |=> aux_reg[7:6] == 2'h0 && aux_reg[5:0] == $past(bus_req.wdata[5:0]))
        else $error("aux control write wrong");

    a_aux_readback: assert property (
        bus_req.rd && bus_req.addr == OCS_ADDR_AUX |=> rd_data == $past(aux_reg))
        else $error("aux register readback wrong");

    a_strap_no_store: assert property (
        bus_req.wr && bus_req.addr == OCS_ADDR_STRAP
        |=> $stable(oe_reg) && $stable(freq_reg) && $stable(aux_reg))
        else $error("write to strap readback changed a register");

    c_port_three_off: cover property (!clk_cfg.port_three_en);
    c_if_override:  cover property (captured_reg && wr_if);
    c_strap_read:   cover property (bus_req.rd && bus_req.addr == OCS_ADDR_STRAP);
    c_port_two_cp:  cover property (clk_cfg.port_two_en
                                    && freq_reg[1:0] == OCS_P2_COPY_A);
    c_dig_b_sonet:  cover property (clk_cfg.dig_b_sonet
                                    && clk_cfg.dig_b_khz == 16'h3040);

endmodule

// >>> verification/ocs_output_clock_select_test.sv
/*
 Self-checking bench for the output clock select register block.
 Assumes the single-cycle register port of the design and straps held steady through reset.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ocs_output_clock_select_test
    import ocs_pkg::*;
;
    logic            sys_clk;
    logic            arst_n;
    ocs_bus_req_type bus_req;
    logic [7:0]      rd_data;
    logic [2:0]      host_interface_strap_pins;
    logic            e1t1_select;
    ocs_if_type      active_if_type;
    logic [5:0]      aux_pll_path_ctrl;
    ocs_clk_cfg_type clk_cfg;
    int              errors;
    int              check_count;
    int              cycles;
    logic [15:0]     p2_exp [4];

    ocs_output_clock_select ocs_output_clock_select_i (
        .sys_clk                   (sys_clk),
        .arst_n                    (arst_n),
        .bus_req                   (bus_req),
        .rd_data                   (rd_data),
        .host_interface_strap_pins (host_interface_strap_pins),
        .e1t1_select               (e1t1_select),
        .active_if_type            (active_if_type),
        .aux_pll_path_ctrl         (aux_pll_path_ctrl),
        .clk_cfg                   (clk_cfg)
    );

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        `CHK(rd_data, e)
    endtask

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        errors = 0;
        check_count = 0;
        cycles = 0;
        p2_exp = '{OCS_KHZ_6M48, OCS_KHZ_25M92, OCS_KHZ_19M44, 16'h1000};
        arst_n = 1'b0;
        bus_req = '0;
        host_interface_strap_pins = 3'h5;
        e1t1_select = 1'b0;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (5) tick();
        // Reset values and strap capture
        `CHK(active_if_type, OCS_IF_SERIAL)
        `CHK(clk_cfg.dig_a_khz, OCS_KHZ_SDH)
        `CHK(clk_cfg.dig_b_khz, OCS_KHZ_SDH)
        `CHK(clk_cfg.port_two_khz, OCS_KHZ_6M48)
        `CHK(clk_cfg.port_three_khz, OCS_KHZ_19M44)
        rd(OCS_ADDR_OE, 8'h1F);
        rd(OCS_ADDR_FREQ, 8'h04);
        rd(OCS_ADDR_AUX, 8'h00);
        rd(OCS_ADDR_STRAP, 8'h05);
        tick();
        `CHK(rd_data, 8'h00)
        test_end("reset");
        // Straps change while running
        host_interface_strap_pins <= 3'h2;
        repeat (4) tick();
        rd(OCS_ADDR_STRAP, 8'h02);
        `CHK(active_if_type, OCS_IF_SERIAL)
        wr(OCS_ADDR_STRAP, 8'h07);
        rd(OCS_ADDR_STRAP, 8'h02);
        rd(8'h36, 8'h00);
        test_end("strap");
        // Active interface select, every code
        for (int c = 0; c < 8; c++) begin
            wr(OCS_ADDR_IF_SEL, {5'h00, 3'(c)});
            tick();
            `CHK(active_if_type, ocs_if_type'(3'(c)))
            rd(OCS_ADDR_IF_SEL, {5'h00, 3'(c)});
        end
        test_end("if_select");
        // Families and digital output codes, a and b differ
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 4; c++) begin
                wr(OCS_ADDR_OE, {1'b0, ~1'(f), 1'(f), 5'h14});
                wr(OCS_ADDR_FREQ, {2'(3 - c), 2'(c), 4'h0});
                tick();
                `CHK(clk_cfg.dig_a_sonet, 1'(f))
                `CHK(clk_cfg.dig_b_sonet, ~1'(f))
                `CHK(clk_cfg.dig_a_khz, (f ? OCS_KHZ_SONET : OCS_KHZ_SDH) << c)
                `CHK(clk_cfg.dig_b_khz, (f ? OCS_KHZ_SDH : OCS_KHZ_SONET) << (3 - c))
            end
        end
        test_end("digital");
        // Port two codes with output a at 4096 kHz
        wr(OCS_ADDR_OE, 8'h14);
        for (int p = 0; p < 4; p++) begin
            wr(OCS_ADDR_FREQ, {4'h1, 2'h0, 2'(p)});
            tick();
            `CHK(clk_cfg.port_two_khz, p2_exp[p])
            `CHK(clk_cfg.port_two_en, 1'b1)
        end
        test_end("port_two");
        // Disabled ports hold a static level
        wr(OCS_ADDR_OE, 8'h04);
        tick();
        `CHK(clk_cfg.port_two_en, 1'b0)
        `CHK(clk_cfg.port_two_khz, OCS_KHZ_OFF)
        `CHK(clk_cfg.port_two_level, OCS_STATIC_LEVEL)
        `CHK(clk_cfg.port_three_en, 1'b1)
        wr(OCS_ADDR_OE, 8'h00);
        tick();
        `CHK(clk_cfg.port_three_en, 1'b0)
        `CHK(clk_cfg.port_three_khz, OCS_KHZ_OFF)
        `CHK(clk_cfg.port_three_level, OCS_STATIC_LEVEL)
        test_end("disable");
        // Unused bits and aux path control
        wr(OCS_ADDR_OE, 8'hF4);
        rd(OCS_ADDR_OE, 8'h74);
        wr(OCS_ADDR_FREQ, 8'hFF);
        rd(OCS_ADDR_FREQ, 8'hF3);
        wr(OCS_ADDR_AUX, 8'hFF);
        rd(OCS_ADDR_AUX, 8'h3F);
        `CHK(aux_pll_path_ctrl, 6'h3F)
        wr(OCS_ADDR_AUX, 8'h15);
        tick();
        `CHK(aux_pll_path_ctrl, 6'h15)
        test_end("masks");
        // E1/T1 select passes through
        e1t1_select <= 1'b1;
        repeat (2) tick();
        `CHK(clk_cfg.e1t1_mode, 1'b1)
        e1t1_select <= 1'b0;
        repeat (2) tick();
        `CHK(clk_cfg.e1t1_mode, 1'b0)
        test_end("e1t1");
        conclude();
    end
endmodule
